// ===== core/video_dac_input_register.sv
// Purpose: Pixel input register and composite level of a video DAC
// Assumes: All pins except the asynchronous reset_in synchronous to mclk_in; single AHB-Lite master
// Notes:   Controls act on the clock, not asynchronously
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module video_dac_input_register
    import video_dac_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        clk_en_in,
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output var  logic [31:0] hrdata_out,
    output var  logic        hreadyout_out,
    output var  logic        hresp_out,
    input  wire logic [7:0]  pixel_in,
    input  wire logic        strobe_in,
    input  wire logic        sync_n_in,
    input  wire logic        blank_n_in,
    input  wire logic        ref_white_n_in,
    input  wire logic        bright_n_in,
    output var  logic [7:0]  pixel_reg_out,
    output var  logic [15:0] level_out
);
    logic [7:0]  pixel_ff;
    logic [7:0]  nxt_pixel_ff;
    logic        strobe_q_ff;
    logic        nxt_strobe_q_ff;
    logic [1:0]  gap_ff;
    logic [1:0]  nxt_gap_ff;
    logic [15:0] level_ff;
    logic [15:0] nxt_level_ff;
    logic [1:0]  ctrl_ff;
    logic [1:0]  nxt_ctrl_ff;
    logic [1:0]  fault_ff;
    logic [1:0]  nxt_fault_ff;
    logic        wr_pend_ff;
    logic        nxt_wr_pend_ff;
    logic [7:0]  addr_ff;
    logic [7:0]  nxt_addr_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata_ff;
    logic        strobe_rise;
    logic        forced_clear;
    logic [1:0]  fault_set;
    logic        bus_take;

    level_if lvl_bus ();

    level_calc u_level_calc
    (
        .lvl (lvl_bus.calc)
    );

    assign lvl_bus.pixel      = pixel_ff;
    assign lvl_bus.sync_n     = sync_n_in;
    assign lvl_bus.blank_n    = blank_n_in;
    assign lvl_bus.bright_n   = bright_n_in;
    assign lvl_bus.setup_open = ctrl_ff[CTRL_SETUP_BIT];
    assign lvl_bus.width8     = ctrl_ff[CTRL_WIDTH8_BIT];

    assign strobe_rise  = strobe_in && !strobe_q_ff;
    assign forced_clear = !sync_n_in || !blank_n_in;

    // Video path, frozen while the clock enable is low
    always_comb
    begin
        nxt_pixel_ff    = pixel_ff;
        nxt_strobe_q_ff = strobe_q_ff;
        nxt_gap_ff      = gap_ff;
        nxt_level_ff    = level_ff;
        fault_set       = 2'h0;
        if (clk_en_in)
        begin
            nxt_strobe_q_ff = strobe_in;
            nxt_level_ff    = lvl_bus.level;
            if (forced_clear)
            begin
                nxt_pixel_ff = PIXEL_CLEAR;
            end
            else if (!ref_white_n_in)
            begin
                nxt_pixel_ff = PIXEL_WHITE;
            end
            else if (strobe_rise)
            begin
                nxt_pixel_ff = ctrl_ff[CTRL_WIDTH8_BIT] ? pixel_in
                                                        : {pixel_in[7:4], 4'h0};
            end
            // Both controls together leave the register undefined on the part
            fault_set[FAULT_CONFLICT_BIT] = forced_clear && !ref_white_n_in;
            // Edges closer than the update period are flagged, still loaded
            if (strobe_rise)
            begin
                fault_set[FAULT_RATE_BIT] = gap_ff < STROBE_GAP_MIN;
                nxt_gap_ff = 2'h1;
            end
            else if (gap_ff != 2'h3)
            begin
                nxt_gap_ff = gap_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pixel_ff    <= PIXEL_RESET;
            strobe_q_ff <= 1'b0;
            gap_ff      <= 2'h3;
            level_ff    <= LEVEL_RESET;
        end
        else
        begin
            pixel_ff    <= nxt_pixel_ff;
            strobe_q_ff <= nxt_strobe_q_ff;
            gap_ff      <= nxt_gap_ff;
            level_ff    <= nxt_level_ff;
        end
    end

    // Bus slave stays live under clock enable so transfers never hang
    assign bus_take = hsel_in && htrans_in[1] && hready_in;

    always_comb
    begin
        nxt_ctrl_ff    = ctrl_ff;
        nxt_fault_ff   = fault_ff;
        nxt_wr_pend_ff = bus_take && hwrite_in;
        nxt_addr_ff    = bus_take ? haddr_in : addr_ff;
        nxt_hrdata_ff  = hrdata_ff;
        if (wr_pend_ff && addr_ff == ADDR_CTRL)
        begin
            nxt_ctrl_ff = hwdata_in[1:0];
        end
        if (wr_pend_ff && addr_ff == ADDR_FAULT)
        begin
            nxt_fault_ff = fault_ff & ~hwdata_in[1:0];
        end
        // Set beats clear in the same cycle
        nxt_fault_ff = nxt_fault_ff | fault_set;
        if (bus_take && !hwrite_in)
        begin
            unique case (haddr_in)
                ADDR_CTRL:  nxt_hrdata_ff = {30'h0, nxt_ctrl_ff};
                ADDR_PIXEL: nxt_hrdata_ff = {24'h0, nxt_pixel_ff};
                ADDR_LEVEL: nxt_hrdata_ff = {16'h0, nxt_level_ff};
                ADDR_FAULT: nxt_hrdata_ff = {30'h0, nxt_fault_ff};
                default:    nxt_hrdata_ff = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ctrl_ff    <= CTRL_RESET;
            fault_ff   <= FAULT_RESET;
            wr_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
            hrdata_ff  <= 32'h0;
        end
        else
        begin
            ctrl_ff    <= nxt_ctrl_ff;
            fault_ff   <= nxt_fault_ff;
            wr_pend_ff <= nxt_wr_pend_ff;
            addr_ff    <= nxt_addr_ff;
            hrdata_ff  <= nxt_hrdata_ff;
        end
    end

    assign hrdata_out    = hrdata_ff;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign pixel_reg_out = pixel_ff;
    assign level_out     = level_ff;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence white_held;
        (clk_en_in && sync_n_in && blank_n_in && !ref_white_n_in && !bright_n_in
         && ctrl_ff[CTRL_WIDTH8_BIT]) [*2];
    endsequence

    sequence capture8;
        clk_en_in && sync_n_in && blank_n_in && ref_white_n_in && strobe_rise
        && ctrl_ff[CTRL_WIDTH8_BIT];
    endsequence

    a_strobe_capture: assert property (capture8 |=> pixel_ff == $past(pixel_in))
        else $error("pixel word not captured on strobe edge");
    a_pixel_hold: assert property (clk_en_in && !forced_clear && ref_white_n_in
        && !strobe_rise |=> $stable(pixel_ff))
        else $error("pixel register changed without strobe edge");
    a_forced_clear: assert property (clk_en_in && forced_clear |=> pixel_ff == PIXEL_CLEAR)
        else $error("sync or blanking did not clear register");
    a_white_level: assert property (white_held |=> pixel_ff == PIXEL_WHITE
        && level_ff == LVL_WHITE_DIM_Q)
        else $error("reference white level wrong");
    a_narrow_drop: assert property (clk_en_in && sync_n_in && blank_n_in && ref_white_n_in
        && strobe_rise && !ctrl_ff[CTRL_WIDTH8_BIT] |=> pixel_ff[3:0] == 4'h0)
        else $error("narrow variant kept low bits");
    a_blank_level: assert property (clk_en_in && sync_n_in && !blank_n_in
        && ctrl_ff[CTRL_SETUP_BIT] |=> level_ff == LVL_BLANK_OPEN_Q)
        else $error("blanked level wrong");
    a_sync_level: assert property (clk_en_in && !sync_n_in && bright_n_in
        && ctrl_ff[CTRL_SETUP_BIT] |=> level_ff == 16'h0000)
        else $error("sync level not at zero");
    a_full_scale: assert property (clk_en_in && pixel_ff == PIXEL_WHITE && !forced_clear
        && bright_n_in && ctrl_ff[CTRL_WIDTH8_BIT] |=> level_ff == LVL_WHITE_BRT_Q)
        else $error("full scale level wrong");
    a_zero_level: assert property (clk_en_in && pixel_ff == PIXEL_CLEAR && !forced_clear
        && bright_n_in |=> level_ff == BLACK_Q)
        else $error("zero word level wrong");
    a_msb_level: assert property (clk_en_in && pixel_ff == 8'h80 && !forced_clear
        && !bright_n_in && ctrl_ff[CTRL_WIDTH8_BIT] |=> level_ff == LVL_MSB_DIM_Q)
        else $error("msb level wrong");
    a_conflict_flag: assert property (clk_en_in && forced_clear && !ref_white_n_in
        |=> fault_ff[FAULT_CONFLICT_BIT] [*1])
        else $error("control conflict not flagged");
endmodule : video_dac_input_register
`default_nettype wire

// ===== include/video_dac_pkg.sv
// Purpose: Shared constants for the video DAC input register block
// Assumes: Levels are held in quarter-millivolt units above sync level
// Notes:   Register offsets are byte addresses on a 32-bit AHB-Lite bus
package video_dac_pkg;
    // Register map
    localparam logic [7:0]  ADDR_CTRL          = 8'h00;
    localparam logic [7:0]  ADDR_PIXEL         = 8'h04;
    localparam logic [7:0]  ADDR_LEVEL         = 8'h08;
    localparam logic [7:0]  ADDR_FAULT         = 8'h0C;
    // Control fields
    localparam int          CTRL_WIDTH8_BIT    = 0;
    localparam int          CTRL_SETUP_BIT     = 1;
    localparam logic [1:0]  CTRL_RESET         = 2'h3;
    // Fault fields, write one to clear
    localparam int          FAULT_CONFLICT_BIT = 0;
    localparam int          FAULT_RATE_BIT     = 1;
    localparam logic [1:0]  FAULT_RESET        = 2'h0;
    // Pixel and level register values
    localparam logic [7:0]  PIXEL_CLEAR        = 8'h00;
    localparam logic [7:0]  PIXEL_WHITE        = 8'hFF;
    localparam logic [7:0]  PIXEL_RESET        = 8'h00;
    localparam logic [15:0] LEVEL_RESET        = 16'h0000;
    // Analog weights, quarter millivolts
    localparam logic [15:0] LSB8_Q             = 16'h000A;
    localparam logic [15:0] LSB4_Q             = 16'h00A0;
    localparam logic [15:0] BLACK_Q            = 16'h0549;
    localparam logic [15:0] SYNC_Q             = 16'h0474;
    localparam logic [15:0] BRIGHT_Q           = 16'h011C;
    localparam logic [15:0] SETUP_OPEN_Q       = 16'h00D5;
    localparam logic [15:0] SETUP_GND_Q        = 16'h0000;
    // Reference results, quarter millivolts
    localparam logic [15:0] LVL_WHITE_DIM_Q    = 16'h105B;
    localparam logic [15:0] LVL_WHITE_BRT_Q    = 16'h0F3F;
    localparam logic [15:0] LVL_MSB_DIM_Q      = 16'h0B65;
    localparam logic [15:0] LVL_BLANK_OPEN_Q   = 16'h0474;
    // Timing
    localparam int          CLK_PERIOD_NS      = 8;
    localparam int          UPDATE_PERIOD_NS   = 20;
    localparam int          MIN_STROBE_CYCLES  =
        (UPDATE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  STROBE_GAP_MIN     = 2'(MIN_STROBE_CYCLES);
endpackage : video_dac_pkg

// ===== include/level_if.sv
// Purpose: Carries register contents and controls to the level encoder
// Assumes: All signals belong to mclk_in
// Notes:   Active-low controls keep their pin polarity
`timescale 1ns/1ns
`default_nettype none
interface level_if;
    logic [7:0]  pixel;
    logic        sync_n;
    logic        blank_n;
    logic        bright_n;
    logic        setup_open;
    logic        width8;
    logic [15:0] level;
    modport calc (input pixel, sync_n, blank_n, bright_n, setup_open, width8, output level);
    modport user (output pixel, sync_n, blank_n, bright_n, setup_open, width8, input level);
endinterface : level_if
`default_nettype wire

// ===== core/level_calc.sv
// Purpose: Composite output level from pixel register and controls
// Assumes: Quarter-millivolt units above sync level
// Notes:   Purely combinational; caller registers the result
`timescale 1ns/1ns
`default_nettype none
module level_calc
    import video_dac_pkg::*;
(
    level_if.calc lvl
);
    logic [15:0] gray;
    logic [15:0] setup;
    logic [15:0] bright;

    always_comb
    begin
        // Four-bit variant weighs only the top nibble
        gray   = lvl.width8 ? 16'(lvl.pixel) * LSB8_Q
                            : 16'(lvl.pixel[7:4]) * LSB4_Q;
        setup  = lvl.setup_open ? SETUP_OPEN_Q : SETUP_GND_Q;
        bright = lvl.bright_n ? 16'h0000 : BRIGHT_Q;
        if (!lvl.sync_n)
        begin
            // Add before subtracting so no step dips below zero
            lvl.level = BLACK_Q + bright - setup - SYNC_Q;
        end
        else if (!lvl.blank_n)
        begin
            lvl.level = BLACK_Q - setup;
        end
        else
        begin
            lvl.level = BLACK_Q + gray + bright;
        end
    end
endmodule : level_calc
`default_nettype wire

// ===== sim/pixel_source.sv
// Purpose: Raster controller model driving pixel words and video controls
// Assumes: Driven from the bench clock, changes just after rising edges
// Notes:   Pixel lines show the inverted word once the strobe has dropped
`timescale 1ns/1ns
`default_nettype none
module pixel_source
(
    input  wire logic       mclk_in,
    output var  logic [7:0] pixel_out,
    output var  logic       strobe_out,
    output var  logic       sync_n_out,
    output var  logic       blank_n_out,
    output var  logic       white_n_out,
    output var  logic       bright_n_out
);
    initial
    begin
        pixel_out    = 8'h00;
        strobe_out   = 1'b0;
        sync_n_out   = 1'b1;
        blank_n_out  = 1'b1;
        white_n_out  = 1'b1;
        bright_n_out = 1'b1;
    end

    // Mixing white with sync or blanking only when a test asks for it
    task automatic set_ctl(input logic s, input logic b, input logic w, input logic br);
        @(posedge mclk_in);
        sync_n_out   <= s;
        blank_n_out  <= b;
        white_n_out  <= w;
        bright_n_out <= br;
    endtask : set_ctl

    // A gap below one breaks the update rate on purpose
    task automatic send(input logic [7:0] word, input int gap);
        @(posedge mclk_in);
        pixel_out  <= word;
        strobe_out <= 1'b1;
        @(posedge mclk_in);
        strobe_out <= 1'b0;
        pixel_out  <= ~word;
        repeat (gap) @(posedge mclk_in);
    endtask : send
endmodule : pixel_source
`default_nettype wire

// ===== sim/test_video_dac_input_register.sv
// Purpose: Self-checking bench for the video DAC input register
// Assumes: Zero-wait AHB-Lite slave, levels in quarter millivolts
// Notes:   Each video check waits four edges for the level to settle
`timescale 1ns/1ns
`default_nettype none
module test_video_dac_input_register
    import video_dac_pkg::*;
;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        clk_en_in = 1'b1;
    logic        hsel_in = 1'b0;
    logic [7:0]  haddr_in = 8'h00;
    logic [1:0]  htrans_in = 2'h0;
    logic        hwrite_in = 1'b0;
    logic [2:0]  hsize_in = 3'h2;
    logic [31:0] hwdata_in = 32'h0;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        hresp_out;
    logic [7:0]  pixel_in, pixel_reg_out;
    logic        strobe_in, sync_n_in, blank_n_in, ref_white_n_in, bright_n_in;
    logic [15:0] level_out;
    logic [31:0] rd;
    int          err_count = 0;
    int          total_checks = 0;
    logic [7:0]  pix_t [4] = '{8'h80, 8'h00, 8'h00, 8'hFF};
    logic        brt_t [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [15:0] lvl_t [4] = '{LVL_MSB_DIM_Q, 16'h0665, BLACK_Q, 16'h0F3F};

    always #4 mclk_in = ~mclk_in;

    video_dac_input_register uut (
        .mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .pixel_in(pixel_in), .strobe_in(strobe_in),
        .sync_n_in(sync_n_in), .blank_n_in(blank_n_in), .ref_white_n_in(ref_white_n_in),
        .bright_n_in(bright_n_in), .pixel_reg_out(pixel_reg_out), .level_out(level_out)
    );

    pixel_source src (
        .mclk_in(mclk_in), .pixel_out(pixel_in), .strobe_out(strobe_in),
        .sync_n_out(sync_n_in), .blank_n_out(blank_n_in), .white_n_out(ref_white_n_in),
        .bright_n_out(bright_n_in)
    );

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Holds each phase until hready is seen high
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge mclk_in);
        hsel_in   <= 1'b1;
        haddr_in  <= a;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        hsel_in   <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
        // Slave never signals an error response
        check({31'h0, hresp_out}, 32'h0);
    endtask : bus

    task automatic expect_out(input logic [7:0] pix, input logic [15:0] lvl);
        repeat (4) @(posedge mclk_in);
        check({24'h0, pixel_reg_out}, {24'h0, pix});
        check({16'h0, level_out}, {16'h0, lvl});
        bus(ADDR_LEVEL, 1'b0, 32'h0);
        check(rd, {16'h0, lvl});
    endtask : expect_out

    initial
    begin
        repeat (20000) @(posedge mclk_in);
        err_count++;
        test_done();
    end

    initial
    begin
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        bus(ADDR_CTRL, 1'b0, 32'h0);
        check(rd, 32'h3);
        bus(ADDR_FAULT, 1'b0, 32'h0);
        check(rd, 32'h0);
        bus(8'h10, 1'b0, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            src.set_ctl(1'b1, 1'b1, 1'b1, brt_t[i]);
            src.send(pix_t[i], 2);
            expect_out(pix_t[i], lvl_t[i]);
        end
        src.set_ctl(1'b1, 1'b1, 1'b0, 1'b0);
        expect_out(PIXEL_WHITE, LVL_WHITE_DIM_Q);
        src.set_ctl(1'b1, 1'b1, 1'b0, 1'b1);
        expect_out(PIXEL_WHITE, LVL_WHITE_BRT_Q);
        src.set_ctl(1'b1, 1'b0, 1'b1, 1'b1);
        src.send(8'h5A, 2);
        expect_out(PIXEL_CLEAR, LVL_BLANK_OPEN_Q);
        bus(ADDR_CTRL, 1'b1, 32'h1);
        expect_out(PIXEL_CLEAR, BLACK_Q);
        bus(ADDR_CTRL, 1'b1, 32'h2);
        bus(ADDR_CTRL, 1'b0, 32'h0);
        check(rd, 32'h2);
        src.set_ctl(1'b0, 1'b1, 1'b1, 1'b1);
        expect_out(PIXEL_CLEAR, 16'h0000);
        src.set_ctl(1'b1, 1'b1, 1'b1, 1'b1);
        src.send(8'hAB, 2);
        expect_out(8'hA0, 16'h0B89);
        bus(ADDR_PIXEL, 1'b1, 32'h77);
        bus(ADDR_PIXEL, 1'b0, 32'h0);
        check(rd, 32'hA0);
        clk_en_in <= 1'b0;
        src.send(8'h30, 2);
        clk_en_in <= 1'b1;
        expect_out(8'hA0, 16'h0B89);
        src.send(8'h10, 0);
        src.send(8'h20, 2);
        expect_out(8'h20, 16'h0689);
        src.set_ctl(1'b0, 1'b1, 1'b0, 1'b1);
        src.set_ctl(1'b1, 1'b1, 1'b1, 1'b1);
        bus(ADDR_FAULT, 1'b0, 32'h0);
        check(rd, 32'h3);
        bus(ADDR_FAULT, 1'b1, 32'h3);
        bus(ADDR_FAULT, 1'b0, 32'h0);
        check(rd, 32'h0);
        test_done();
    end
endmodule : test_video_dac_input_register
`default_nettype wire
